// ---- acc_pkg.sv ----
package acc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0]  ACC_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  ACC_SETUP_OFS  = 8'h04;
  localparam logic [7:0]  ACC_STATUS_OFS = 8'h20;
  localparam logic [7:0]  ACC_UPPER_OFS  = 8'h24;
  localparam logic [7:0]  ACC_LOWER_OFS  = 8'h28;
  localparam logic [7:0]  ACC_OFFSET_OFS = 8'h18;
  // ----------------------------------------
  // Control, setup and status bit positions
  // ----------------------------------------
  localparam int ACC_ON_BIT    = 0;
  localparam int ACC_CALIBRATION_ENABLE_BIT = 1;
  localparam int ACC_START_BIT = 2;
  localparam int ACC_STOP_BIT  = 4;
  localparam int ACC_COMP_BIT  = 5;
  localparam int ACC_RSTC_BIT  = 6;
  localparam int ACC_AUTO_BIT  = 7;
  localparam int ACC_MIC_BIT   = 8;
  localparam int ACC_DMA_BIT   = 9;
  localparam int ACC_SKIP_BIT  = 18;
  localparam int ACC_HIT_BIT   = 0;
  localparam int ACC_CONT_BIT  = 11;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [9:0]  ACC_CTRL_RST   = 10'h000;
  localparam logic [31:0] ACC_SETUP_RST  = 32'h0000000c;
  localparam logic [31:0] ACC_UPPER_RST  = 32'hffffffff;
  localparam logic [31:0] ACC_LOWER_RST  = 32'h00000000;
  localparam logic [31:0] ACC_OFFSET_RST = 32'h00000000;
  // ----------------------------------------
  // Channel selector codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    ACC_CH_OPEN  = 3'h0,
    ACC_CH_PIN2  = 3'h1,
    ACC_CH_PIN1  = 3'h2,
    ACC_CH_DIFF  = 3'h3,
    ACC_CH_TEMP  = 3'h4,
    ACC_CH_BATT  = 3'h5,
    ACC_CH_SHORT = 3'h6
  } acc_chan_t;
  // Switch vector: {pos_pin1, pos_vref, neg_pin2, neg_vref, neg_temp, neg_batt}
  localparam logic [5:0] ACC_SW_OPEN  = 6'h00;
  localparam logic [5:0] ACC_SW_PIN2  = 6'h12;
  localparam logic [5:0] ACC_SW_PIN1  = 6'h24;
  localparam logic [5:0] ACC_SW_DIFF  = 6'h28;
  localparam logic [5:0] ACC_SW_TEMP  = 6'h11;
  localparam logic [5:0] ACC_SW_BATT  = 6'h11;
  localparam logic [5:0] ACC_SW_SHORT = 6'h14;
  localparam logic [1:0] ACC_NEG_TEMP = 2'h2;
  localparam logic [1:0] ACC_NEG_BATT = 2'h1;
endpackage

// ---- acc_control.sv ----
`timescale 1ns/1ps
// How it works
// - Stop bit ends conversion, powers down, reads zero
// - Stop clears start, power, DMA, microphone bits
// - Bit 5 enables window compare hit flag
// - Bit 6 disables calibration, self-clears, reads zero
// - Calibrate only with auto-offset and enable set
// - Bit 8 powers analogue in microphone mode
// - Codes 000, 001, 010 open or single-ended
// - Code 011 gives differential pin1 minus pin2
// - Codes 100, 101 temperature, battery versus 0.6 V
// - Code 110 shorts inputs, reset value
// - Unbypassed filter uses upper halves for results
module acc_control (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        conv_done_in,
  input  wire logic [15:0] conv_value_in,
  input  wire logic        cal_done_in,
  input  wire logic [15:0] cal_value_in,
  output logic      [31:0] rdata_out,
  output logic             power_on_out,
  output logic             mic_power_out,
  output logic             start_out,
  output logic             stop_out,
  output logic             cal_run_out,
  output logic             dma_req_out,
  output logic             window_hit_out,
  output logic      [5:0]  switch_out,
  output logic      [1:0]  neg_sensor_out,
  output logic             skip_out
);
  import acc_pkg::*;

  logic [9:0]  control_word;
  logic [31:0] setup_word;
  logic [31:0] upper_limit;
  logic [31:0] lower_limit;
  logic [31:0] offset_word;
  logic        window_hit_flag;
  logic        calibration_enable;
  logic        wr_ctrl;
  logic        wr_setup;
  logic        stop_req;
  logic        cal_off_req;
  logic [31:0] conv_word;
  logic        in_window;
  acc_chan_t   input_channel_selector;

  assign wr_ctrl     = wr_en_in && (addr_in == ACC_CTRL_OFS);
  assign wr_setup    = wr_en_in && (addr_in == ACC_SETUP_OFS);
  assign stop_req    = wr_ctrl && wdata_in[ACC_STOP_BIT];
  assign cal_off_req = wr_ctrl && wdata_in[ACC_RSTC_BIT];
  assign input_channel_selector = acc_chan_t'(setup_word[3:1]);
  assign calibration_enable = control_word[ACC_CALIBRATION_ENABLE_BIT];

  function automatic logic [31:0] place_half(input logic [15:0] v, input logic skip);
    place_half = skip ? {16'h0000, v} : {v, 16'h0000};
  endfunction

  assign conv_word = place_half(conv_value_in, setup_word[ACC_SKIP_BIT]);
  assign in_window = (conv_word <= upper_limit) && (conv_word >= lower_limit);

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      control_word <= ACC_CTRL_RST;
    end else if (wr_ctrl) begin
      control_word <= wdata_in[9:0];
      control_word[ACC_STOP_BIT] <= 1'b0;
      control_word[ACC_RSTC_BIT] <= 1'b0;
      control_word[ACC_CALIBRATION_ENABLE_BIT] <= wdata_in[ACC_CALIBRATION_ENABLE_BIT] ||
                                     (calibration_enable && !wdata_in[ACC_RSTC_BIT]);
      if (wdata_in[ACC_RSTC_BIT]) begin
        control_word[ACC_CALIBRATION_ENABLE_BIT] <= 1'b0;
      end
      if (wdata_in[ACC_STOP_BIT]) begin
        control_word[ACC_START_BIT] <= 1'b0;
        control_word[ACC_ON_BIT]    <= 1'b0;
        control_word[ACC_DMA_BIT]   <= 1'b0;
        control_word[ACC_MIC_BIT]   <= 1'b0;
      end
    end else if (control_word[ACC_START_BIT] && conv_done_in && !setup_word[ACC_CONT_BIT]) begin
      control_word[ACC_START_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      setup_word <= ACC_SETUP_RST;
    end else if (wr_setup) begin
      setup_word <= wdata_in;
    end
  end

  // ----------------------------------------
  // Thresholds and offset
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      upper_limit <= ACC_UPPER_RST;
      lower_limit <= ACC_LOWER_RST;
    end else if (wr_en_in) begin
      if (addr_in == ACC_UPPER_OFS) begin
        upper_limit <= wdata_in;
      end
      if (addr_in == ACC_LOWER_OFS) begin
        lower_limit <= wdata_in;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      offset_word <= ACC_OFFSET_RST;
    end else if (cal_done_in && cal_run_out) begin
      offset_word <= place_half(cal_value_in, setup_word[ACC_SKIP_BIT]);
    end else if (wr_en_in && addr_in == ACC_OFFSET_OFS) begin
      offset_word <= wdata_in;
    end
  end

  // ----------------------------------------
  // Window comparator flag
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      window_hit_flag <= 1'b0;
    end else if (conv_done_in && control_word[ACC_COMP_BIT] && in_window) begin
      window_hit_flag <= 1'b1;
    end else if (wr_en_in && addr_in == ACC_STATUS_OFS && wdata_in[ACC_HIT_BIT]) begin
      window_hit_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rdata_out <= 32'h00000000;
    end else if (rd_en_in) begin
      case (addr_in)
        ACC_CTRL_OFS:   rdata_out <= {22'h000000, control_word};
        ACC_SETUP_OFS:  rdata_out <= setup_word;
        ACC_STATUS_OFS: rdata_out <= {31'h00000000, window_hit_flag};
        ACC_UPPER_OFS:  rdata_out <= upper_limit;
        ACC_LOWER_OFS:  rdata_out <= lower_limit;
        ACC_OFFSET_OFS: rdata_out <= offset_word;
        default:        rdata_out <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // Analogue control outputs
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      power_on_out   <= 1'b0;
      mic_power_out  <= 1'b0;
      start_out      <= 1'b0;
      stop_out       <= 1'b0;
      cal_run_out    <= 1'b0;
      dma_req_out    <= 1'b0;
      window_hit_out <= 1'b0;
      skip_out       <= 1'b0;
    end else begin
      power_on_out   <= control_word[ACC_ON_BIT];
      mic_power_out  <= control_word[ACC_MIC_BIT];
      start_out      <= control_word[ACC_START_BIT] && control_word[ACC_ON_BIT];
      stop_out       <= stop_req;
      cal_run_out    <= control_word[ACC_AUTO_BIT] && calibration_enable;
      dma_req_out    <= conv_done_in && control_word[ACC_DMA_BIT];
      window_hit_out <= window_hit_flag;
      skip_out       <= setup_word[ACC_SKIP_BIT];
    end
  end

  // ----------------------------------------
  // Input switch matrix
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      switch_out     <= ACC_SW_SHORT;
      neg_sensor_out <= 2'h0;
    end else begin
      neg_sensor_out <= 2'h0;
      case (input_channel_selector)
        ACC_CH_OPEN:  switch_out <= ACC_SW_OPEN;
        ACC_CH_PIN2:  switch_out <= ACC_SW_PIN2;
        ACC_CH_PIN1:  switch_out <= ACC_SW_PIN1;
        ACC_CH_DIFF:  switch_out <= ACC_SW_DIFF;
        ACC_CH_TEMP: begin
          switch_out     <= ACC_SW_TEMP;
          neg_sensor_out <= ACC_NEG_TEMP;
        end
        ACC_CH_BATT: begin
          switch_out     <= ACC_SW_BATT;
          neg_sensor_out <= ACC_NEG_BATT;
        end
        ACC_CH_SHORT: switch_out <= ACC_SW_SHORT;
        default:      switch_out <= ACC_SW_OPEN;
      endcase
    end
  end
endmodule

// ---- acc_control_properties.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Port checks
// ----------------------------------------
module acc_control_properties
  import acc_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        rst_in,
  input wire logic        wr_en_in,
  input wire logic        rd_en_in,
  input wire logic [7:0]  addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        conv_done_in,
  input wire logic [31:0] rdata_out,
  input wire logic        power_on_out,
  input wire logic        mic_power_out,
  input wire logic        start_out,
  input wire logic        stop_out,
  input wire logic        cal_run_out,
  input wire logic        dma_req_out,
  input wire logic [5:0]  switch_out,
  input wire logic [1:0]  neg_sensor_out
);
  logic ctrl_wr;
  logic setup_wr;
  assign ctrl_wr = wr_en_in && addr_in == ACC_CTRL_OFS;
  assign setup_wr = wr_en_in && addr_in == ACC_SETUP_OFS;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  a_stop_pulse: assert property (ctrl_wr && wdata_in[4] |=> stop_out ##1 !stop_out)
    else $error("stop pulse wrong");
  a_stop_clears: assert property (ctrl_wr && wdata_in[4] |-> ##2
    !(power_on_out || mic_power_out || start_out)) else $error("stop left bits set");
  a_ctrl_readback: assert property (rd_en_in && addr_in == ACC_CTRL_OFS |=>
    rdata_out[31:10] == 22'h0 && !rdata_out[4] && !rdata_out[6]) else $error("ctrl read");
  a_dma_cause: assert property (dma_req_out |-> $past(conv_done_in))
    else $error("dma without conversion");
  a_mic_power: assert property (ctrl_wr && wdata_in[8] && !wdata_in[4] |-> ##2 mic_power_out)
    else $error("mic power missing");
  a_cal_run: assert property (ctrl_wr && wdata_in[7] && wdata_in[1] && !wdata_in[6]
    |-> ##2 cal_run_out) else $error("cal not running");
  a_cal_off: assert property (ctrl_wr && wdata_in[6] |-> ##2 !cal_run_out)
    else $error("cal not stopped");
  a_diff_route: assert property (setup_wr && wdata_in[3:1] == 3'h3
    |-> ##2 switch_out == ACC_SW_DIFF) else $error("diff route");
  a_sensor_route: assert property (setup_wr && wdata_in[3:1] == 3'h4 |-> ##2
    switch_out == ACC_SW_TEMP && neg_sensor_out == ACC_NEG_TEMP) else $error("temp route");
  a_reset_short: assert property ($fell(rst_in) |-> switch_out == ACC_SW_SHORT)
    else $error("reset route");
  c_stop: cover property (stop_out);
  c_dma: cover property (dma_req_out);
  c_cal: cover property (cal_run_out);
endmodule
bind acc_control acc_control_properties u_props (.mclk_in(mclk_in), .rst_in(rst_in),
  .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .conv_done_in(conv_done_in), .rdata_out(rdata_out), .power_on_out(power_on_out),
  .mic_power_out(mic_power_out), .start_out(start_out), .stop_out(stop_out),
  .cal_run_out(cal_run_out), .dma_req_out(dma_req_out), .switch_out(switch_out),
  .neg_sensor_out(neg_sensor_out));

// ---- test_adc_control_channel_select.sv ----
`timescale 1ns/1ps
module test_adc_control_channel_select;
  import acc_pkg::*;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  logic        mclk_in = 0;
  logic        rst_in = 1;
  logic        wr_en_in = 0;
  logic        rd_en_in = 0;
  logic        conv_done_in = 0;
  logic        cal_done_in = 0;
  logic [7:0]  addr_in = 0;
  logic [31:0] wdata_in = 0;
  logic [15:0] conv_value_in = 0;
  logic [15:0] cal_value_in = 0;
  logic [31:0] rdata_out;
  logic        power_on_out, mic_power_out, start_out, stop_out, cal_run_out;
  logic        dma_req_out, window_hit_out, skip_out;
  logic [5:0]  switch_out;
  logic [1:0]  neg_sensor_out;
  logic [5:0]  sw_tab [7] = '{6'h00, 6'h12, 6'h24, 6'h28, 6'h11, 6'h11, 6'h14};
  int          errors = 0;
  int          checked = 0;
  int          cycles = 0;
  always #25 mclk_in = ~mclk_in;
  acc_control dut (.mclk_in(mclk_in), .rst_in(rst_in), .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in), .addr_in(addr_in), .wdata_in(wdata_in), .conv_done_in(conv_done_in),
    .conv_value_in(conv_value_in), .cal_done_in(cal_done_in), .cal_value_in(cal_value_in),
    .rdata_out(rdata_out), .power_on_out(power_on_out), .mic_power_out(mic_power_out),
    .start_out(start_out), .stop_out(stop_out), .cal_run_out(cal_run_out),
    .dma_req_out(dma_req_out), .window_hit_out(window_hit_out), .switch_out(switch_out),
    .neg_sensor_out(neg_sensor_out), .skip_out(skip_out));
  task automatic print_verdict;
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      print_verdict;
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cyc(1);
    wr_en_in = 1;
    addr_in = a;
    wdata_in = d;
    cyc(1);
    wr_en_in = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    cyc(1);
    rd_en_in = 1;
    addr_in = a;
    cyc(1);
    rd_en_in = 0;
    chk(nm, exp, rdata_out);
  endtask
  task automatic conv(input logic [15:0] v);
    cyc(1);
    conv_value_in = v;
    conv_done_in = 1;
    cyc(1);
    conv_done_in = 0;
  endtask
  task automatic t_channels;
    for (int c = 0; c < 7; c++) begin
      wr(ACC_SETUP_OFS, 32'(c) << 1);
      cyc(1);
      chk("switch", sw_tab[c], switch_out);
      chk("sensor", c == 4 ? 2'h2 : c == 5 ? 2'h1 : 2'h0, neg_sensor_out);
    end
  endtask
  task automatic t_stop;
    wr(ACC_CTRL_OFS, 32'h00000305);
    cyc(1);
    chk("levels", 32'h7, {power_on_out, start_out, mic_power_out});
    wr(ACC_CTRL_OFS, 32'h00000010);
    chk("stop", 32'h1, stop_out);
    cyc(1);
    chk("levels", 32'h0, {power_on_out, start_out, mic_power_out, stop_out});
    rd(ACC_CTRL_OFS, 32'h0, "ctrl");
    conv(16'h0100);
    chk("dma", 32'h0, dma_req_out);
  endtask
  task automatic t_dma_window;
    wr(ACC_CTRL_OFS, 32'h00000200);
    conv(16'h0000);
    chk("dma", 32'h1, dma_req_out);
    wr(ACC_CTRL_OFS, 32'h00000000);
    conv(16'h0100);
    cyc(1);
    chk("hit", 32'h0, window_hit_out);
    wr(ACC_CTRL_OFS, 32'hfffffc20);
    rd(ACC_CTRL_OFS, 32'h20, "ctrl");
    conv(16'h0100);
    cyc(1);
    chk("hit", 32'h1, window_hit_out);
  endtask
  task automatic t_start;
    wr(ACC_CTRL_OFS, 32'h00000005);
    cyc(1);
    chk("start", 32'h1, start_out);
    conv(16'h0000);
    cyc(1);
    chk("start", 32'h0, start_out);
    wr(ACC_SETUP_OFS, 32'h0000080c);
    wr(ACC_CTRL_OFS, 32'h00000005);
    conv(16'h0000);
    cyc(1);
    chk("start", 32'h1, start_out);
    wr(ACC_SETUP_OFS, 32'h0000000c);
    wr(ACC_CTRL_OFS, 32'h00000000);
  endtask
  task automatic t_cal;
    wr(ACC_CTRL_OFS, 32'h00000082);
    cyc(1);
    chk("cal", 32'h1, cal_run_out);
    cyc(1);
    cal_value_in = 16'h1234;
    cal_done_in = 1;
    cyc(1);
    cal_done_in = 0;
    rd(ACC_OFFSET_OFS, 32'h12340000, "offset");
    wr(ACC_CTRL_OFS, 32'h000000c0);
    cyc(1);
    chk("cal", 32'h0, cal_run_out);
    rd(ACC_CTRL_OFS, 32'h80, "ctrl");
    cal_value_in = 16'habcd;
    cal_done_in = 1;
    cyc(1);
    cal_done_in = 0;
    rd(ACC_OFFSET_OFS, 32'h12340000, "offset");
    wr(ACC_SETUP_OFS, 32'h0004000c);
    cyc(1);
    chk("skip", 32'h1, skip_out);
    wr(ACC_CTRL_OFS, 32'h00000082);
    cyc(2);
    cal_value_in = 16'h5678;
    cal_done_in = 1;
    cyc(1);
    cal_done_in = 0;
    rd(ACC_OFFSET_OFS, 32'h00005678, "offset");
  endtask
  initial begin
    repeat (10) @(posedge mclk_in);
    #1;
    rst_in = 0;
    rd(ACC_SETUP_OFS, 32'h0000000c, "setup");
    chk("switch", 32'h14, switch_out);
    t_channels;
    t_stop;
    t_dma_window;
    t_start;
    t_cal;
    print_verdict;
  end
endmodule
